// ### spc_position_status.sv
`timescale 1ns/1ps
module spc_position_status #(
  parameter int POS_W = 24
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic link_clk_i,
  input wire logic link_data_i,
  output logic poll_req_o,
  output logic [15:0] status_o,
  output logic irq_o
);

  localparam int FRAME_W = POS_W + spc_pkg::ENC_ST_W;
  localparam int CNT_W = $clog2(FRAME_W + 1);
  localparam int IDLE_W = $clog2(spc_pkg::IDLE_CYC + 1);
  localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_W - 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(spc_pkg::IDLE_CYC);

  generate
    if (POS_W < 2 || POS_W > 28)
    begin : g_bad_width
      $error("POS_W must lie between 2 and 28");
    end
  endgenerate

  // Returns {at_or_above, equal}
  function automatic logic [1:0] spc_cmp(input logic [POS_W-1:0] pos,
                                          input logic [POS_W-1:0] refv);
    spc_cmp = {pos >= refv, pos == refv};
  endfunction : spc_cmp

  // Registers
  logic halt_req;
  logic [POS_W-1:0] low_limit;
  logic [POS_W-1:0] high_limit;
  logic [POS_W-1:0] compare_ref1;
  logic [POS_W-1:0] compare_ref2;
  logic [POS_W-1:0] position_value;
  logic [spc_pkg::ENC_ST_W-1:0] diag_en;
  logic [spc_pkg::ENC_ST_W-1:0] encoder_status_bits;
  logic [spc_pkg::EV_W-1:0] irq_stat;
  logic [spc_pkg::EV_W-1:0] irq_mask;

  // Status bits
  logic comm_halted;
  logic param_reject_flag;
  logic below_low_limit;
  logic above_high_limit;
  logic encoder_signal_fault;
  logic encoder_diag_summary;
  logic counting_up;
  logic counting_down;
  logic at_or_above_ref1;
  logic equal_ref1;
  logic sticky_match1;
  logic at_or_above_ref2;
  logic equal_ref2;
  logic sticky_match2;
  logic have_pos;

  // Link synchronisers and receiver
  logic clk_s1;
  logic clk_s2;
  logic clk_s3;
  logic dat_s1;
  logic dat_s2;
  spc_pkg::spc_link_state_t link_state;
  spc_pkg::spc_link_state_t next_link_state;
  logic [FRAME_W-1:0] shift;
  logic [CNT_W-1:0] bit_cnt;
  logic [IDLE_W-1:0] idle_cnt;

  // Bus decode
  wire sel_ctrl = wr_i && addr_i == spc_pkg::OFS_CTRL;
  wire wr_low = wr_i && addr_i == spc_pkg::OFS_LOW_LIMIT;
  wire wr_high = wr_i && addr_i == spc_pkg::OFS_HIGH_LIMIT;
  wire wr_ref1 = wr_i && addr_i == spc_pkg::OFS_REF1;
  wire wr_ref2 = wr_i && addr_i == spc_pkg::OFS_REF2;
  wire wr_status = wr_i && addr_i == spc_pkg::OFS_STATUS;
  wire wr_diag_en = wr_i && addr_i == spc_pkg::OFS_DIAG_EN;
  wire wr_irq_stat = wr_i && addr_i == spc_pkg::OFS_IRQ_STAT;
  wire wr_irq_mask = wr_i && addr_i == spc_pkg::OFS_IRQ_MASK;
  wire clr1 = (sel_ctrl && wdata_i[spc_pkg::CTRL_CLR1]) || wr_status;
  wire clr2 = (sel_ctrl && wdata_i[spc_pkg::CTRL_CLR2]) || wr_status;

  // Link edge and idle detection
  wire link_rise = clk_s2 && !clk_s3;
  wire link_idle = idle_cnt == IDLE_LAST;
  wire frame_end = link_state == spc_pkg::LS_SHIFT && link_rise && bit_cnt == FRAME_LAST;
  wire [FRAME_W-1:0] frame_word = {shift[FRAME_W-2:0], dat_s2};
  wire next_param_reject = low_limit > high_limit;
  wire next_halted = halt_req || param_reject_flag;
  wire acquire = frame_end && !comm_halted;
  wire [POS_W-1:0] new_pos = frame_word[FRAME_W-1:spc_pkg::ENC_ST_W];
  wire [spc_pkg::ENC_ST_W-1:0] new_enc_st = frame_word[spc_pkg::ENC_ST_W-1:0];
  wire [1:0] cmp1 = spc_cmp(new_pos, compare_ref1);
  wire [1:0] cmp2 = spc_cmp(new_pos, compare_ref2);
  wire fault_now = link_idle && (!dat_s2 || link_state == spc_pkg::LS_SHIFT);
  wire fault_clear = link_idle && dat_s2 && link_state != spc_pkg::LS_SHIFT;
  wire next_fault = fault_now || (encoder_signal_fault && !fault_clear);

  // Events
  wire [spc_pkg::EV_W-1:0] events = {
    fault_now && !encoder_signal_fault,
    acquire && cmp2[0],
    acquire && cmp1[0],
    acquire
  };

  // Process input image
  wire [15:0] next_status = {
    counting_up, counting_down,
    at_or_above_ref2, sticky_match2, equal_ref2,
    at_or_above_ref1, sticky_match1, equal_ref1,
    comm_halted, 2'b00, param_reject_flag,
    below_low_limit, above_high_limit, encoder_signal_fault, encoder_diag_summary
  };

  // Read selection
  wire [31:0] read_mux =
    addr_i == spc_pkg::OFS_CTRL ? {31'h0000_0000, halt_req} :
    addr_i == spc_pkg::OFS_LOW_LIMIT ? 32'(low_limit) :
    addr_i == spc_pkg::OFS_HIGH_LIMIT ? 32'(high_limit) :
    addr_i == spc_pkg::OFS_REF1 ? 32'(compare_ref1) :
    addr_i == spc_pkg::OFS_REF2 ? 32'(compare_ref2) :
    addr_i == spc_pkg::OFS_POSITION ? 32'(position_value) :
    addr_i == spc_pkg::OFS_STATUS ? {16'h0000, status_o} :
    addr_i == spc_pkg::OFS_DIAG_EN ? 32'(diag_en) :
    addr_i == spc_pkg::OFS_IRQ_STAT ? 32'(irq_stat) :
    addr_i == spc_pkg::OFS_IRQ_MASK ? 32'(irq_mask) :
    spc_pkg::RST_WORD;

  // Receiver state
  always_comb
  begin
    next_link_state = link_state;
    case (link_state)
      spc_pkg::LS_IDLE:
      begin
        if (link_rise)
          next_link_state = spc_pkg::LS_SHIFT;
      end
      spc_pkg::LS_SHIFT:
      begin
        if (frame_end)
          next_link_state = spc_pkg::LS_DONE;
        else if (link_idle)
          next_link_state = spc_pkg::LS_IDLE;
      end
      spc_pkg::LS_DONE:
      begin
        if (link_idle)
          next_link_state = spc_pkg::LS_IDLE;
      end
      default:
        next_link_state = spc_pkg::LS_IDLE;
    endcase
  end

  // Synchronisers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      // Idle-high level, no false edge after reset
      clk_s1 <= 1'b1;
      clk_s2 <= 1'b1;
      clk_s3 <= 1'b1;
      dat_s1 <= 1'b1;
      dat_s2 <= 1'b1;
    end
    else
    begin
      clk_s1 <= link_clk_i;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= link_data_i;
      dat_s2 <= dat_s1;
    end
  end

  // Frame shifter and idle timer
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      link_state <= spc_pkg::LS_IDLE;
      shift <= '0;
      bit_cnt <= '0;
      idle_cnt <= '0;
    end
    else
    begin
      link_state <= next_link_state;
      if (link_rise)
        idle_cnt <= '0;
      else if (!link_idle)
        idle_cnt <= idle_cnt + IDLE_W'(1);
      if (link_rise && link_state != spc_pkg::LS_DONE)
      begin
        shift <= frame_word;
        bit_cnt <= link_state == spc_pkg::LS_IDLE ? CNT_W'(1) : bit_cnt + CNT_W'(1);
      end
    end
  end

  // Host-written registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      halt_req <= 1'b0;
      low_limit <= '0;
      high_limit <= '0;
      compare_ref1 <= '0;
      compare_ref2 <= '0;
      diag_en <= '0;
      irq_mask <= '0;
    end
    else
    begin
      if (sel_ctrl)
        halt_req <= wdata_i[spc_pkg::CTRL_HALT];
      if (wr_low)
        low_limit <= wdata_i[POS_W-1:0];
      if (wr_high)
        high_limit <= wdata_i[POS_W-1:0];
      if (wr_ref1)
        compare_ref1 <= wdata_i[POS_W-1:0];
      if (wr_ref2)
        compare_ref2 <= wdata_i[POS_W-1:0];
      if (wr_diag_en)
        diag_en <= wdata_i[spc_pkg::ENC_ST_W-1:0];
      if (wr_irq_mask)
        irq_mask <= wdata_i[spc_pkg::EV_W-1:0];
    end
  end

  // Halt, parameter and fault flags
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      comm_halted <= 1'b0;
      param_reject_flag <= 1'b0;
      encoder_signal_fault <= 1'b0;
      poll_req_o <= 1'b0;
    end
    else
    begin
      comm_halted <= next_halted;
      param_reject_flag <= next_param_reject;
      encoder_signal_fault <= next_fault;
      poll_req_o <= !next_halted;
    end
  end

  // Position evaluation per acquired word
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      position_value <= '0;
      encoder_status_bits <= '0;
      have_pos <= 1'b0;
      below_low_limit <= 1'b0;
      above_high_limit <= 1'b0;
      counting_up <= 1'b0;
      counting_down <= 1'b0;
      {at_or_above_ref1, equal_ref1} <= 2'b00;
      {at_or_above_ref2, equal_ref2} <= 2'b00;
    end
    else if (acquire)
    begin
      position_value <= new_pos;
      encoder_status_bits <= new_enc_st;
      have_pos <= 1'b1;
      below_low_limit <= new_pos < low_limit;
      above_high_limit <= new_pos > high_limit;
      counting_up <= have_pos && new_pos > position_value;
      counting_down <= have_pos && new_pos < position_value;
      {at_or_above_ref1, equal_ref1} <= cmp1;
      {at_or_above_ref2, equal_ref2} <= cmp2;
    end
  end

  // Diagnostic summary
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      encoder_diag_summary <= 1'b0;
    else
      encoder_diag_summary <= |(encoder_status_bits & diag_en);
  end

  // Sticky match markers, set wins over clear
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sticky_match1 <= 1'b0;
      sticky_match2 <= 1'b0;
    end
    else
    begin
      sticky_match1 <= (acquire && cmp1[0]) || (clr1 ? equal_ref1 : sticky_match1);
      sticky_match2 <= (acquire && cmp2[0]) || (clr2 ? equal_ref2 : sticky_match2);
    end
  end

  // Interrupt status, mask and output
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      irq_stat <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_stat <= events | (irq_stat & ~(wr_irq_stat ? wdata_i[spc_pkg::EV_W-1:0] : '0));
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // Status image and read data
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      status_o <= '0;
      rdata_o <= spc_pkg::RST_WORD;
    end
    else
    begin
      status_o <= next_status;
      rdata_o <= rd_i ? read_mux : spc_pkg::RST_WORD;
    end
  end

endmodule : spc_position_status

// ### spc_pkg.sv
package spc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LOW_LIMIT = 8'h04;
  localparam logic [7:0] OFS_HIGH_LIMIT = 8'h08;
  localparam logic [7:0] OFS_REF1 = 8'h0c;
  localparam logic [7:0] OFS_REF2 = 8'h10;
  localparam logic [7:0] OFS_POSITION = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_DIAG_EN = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // Control register bits
  localparam int CTRL_HALT = 0;
  localparam int CTRL_CLR1 = 1;
  localparam int CTRL_CLR2 = 2;

  // Status word bits, byte 0 low, byte 1 high
  localparam int ST_DIAG = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_ABOVE = 2;
  localparam int ST_BELOW = 3;
  localparam int ST_PARAM = 4;
  localparam int ST_HALTED = 7;
  localparam int ST_EQ1 = 8;
  localparam int ST_MARK1 = 9;
  localparam int ST_REL1 = 10;
  localparam int ST_EQ2 = 11;
  localparam int ST_MARK2 = 12;
  localparam int ST_REL2 = 13;
  localparam int ST_DOWN = 14;
  localparam int ST_UP = 15;

  // Interrupt event bits
  localparam int EV_NEWPOS = 0;
  localparam int EV_MATCH1 = 1;
  localparam int EV_MATCH2 = 2;
  localparam int EV_FAULT = 3;
  localparam int EV_W = 4;

  // Encoder status bits carried after the position in each frame
  localparam int ENC_ST_W = 4;

  // Link idle gap ending a frame
  localparam int CLK_NS = 10;
  localparam int IDLE_NS = 2000;
  localparam int IDLE_CYC = (IDLE_NS + CLK_NS - 1) / CLK_NS;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_SHIFT = 2'b01,
    LS_DONE = 2'b10
  } spc_link_state_t;

endpackage : spc_pkg

// ### spc_position_status_checker.sv
`timescale 1ns/1ps
module spc_position_status_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic poll_req_o,
  input wire logic [15:0] status_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // A marker may only drop shortly after a write
  sequence s_wr_recent;
    $past(wr_i) || $past(wr_i, 2);
  endsequence
  chk_halt_poll: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> status_o[7] == !$past(poll_req_o))
    else $error("halted bit disagrees with polling");
  chk_param_halt: assert property (status_o[4] |-> ##[0:2] status_o[7])
    else $error("parameter reject without halt");
  chk_unused_zero: assert property (status_o[6:5] == 2'h0)
    else $error("unused status bits set");
  chk_eq1_rel: assert property (status_o[8] |-> status_o[10])
    else $error("equal1 without at-or-above1");
  chk_eq2_rel: assert property (status_o[11] |-> status_o[13])
    else $error("equal2 without at-or-above2");
  chk_dir_excl: assert property (!(status_o[15] && status_o[14]))
    else $error("both directions set");
  chk_mark1_set: assert property ($rose(status_o[8]) |-> status_o[9])
    else $error("marker1 missed a match");
  chk_mark2_set: assert property ($rose(status_o[11]) |-> status_o[12])
    else $error("marker2 missed a match");
  chk_mark1_clear: assert property ($fell(status_o[9]) |-> s_wr_recent)
    else $error("marker1 dropped without a write");
  chk_mark2_clear: assert property ($fell(status_o[12]) |-> s_wr_recent)
    else $error("marker2 dropped without a write");
  chk_halt_freeze: assert property (status_o[7] && $past(status_o[7])
    |-> $stable({status_o[15:13], status_o[11:10], status_o[8]}))
    else $error("results moved while halted");
endmodule : spc_position_status_checker
bind spc_position_status spc_position_status_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .wr_i(wr_i), .poll_req_o(poll_req_o), .status_o(status_o));

// ### spc_enc_model.sv
`timescale 1ns/1ps
module spc_enc_model #(
  parameter int POS_W = 8
) (
  input wire logic go_i,
  input wire logic cut_i,
  input wire logic [POS_W+3:0] word_i,
  output logic link_clk_o,
  output logic link_data_o,
  output logic busy_o
);
  logic drv;
  initial
  begin
    link_clk_o = 1'b1;
    drv = 1'b1;
    busy_o = 1'b0;
  end
  // Broken cable reads low, released line idles high
  assign link_data_o = cut_i ? 1'b0 : drv;
  always @(posedge go_i)
  begin
    busy_o <= 1'b1;
    for (int i = POS_W + 3; i >= 0; i--)
    begin
      link_clk_o <= 1'b0;
      drv <= word_i[i];
      #40;
      link_clk_o <= 1'b1;
      #40;
    end
    drv <= 1'b1;
    busy_o <= 1'b0;
  end
endmodule : spc_enc_model

// ### ssi_position_status_compare_tb.sv
`timescale 1ns/1ps
module ssi_position_status_compare_tb;
  localparam int PW = 8;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} spc_note_t;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic go = 1'b0;
  logic cut = 1'b0;
  logic [PW+3:0] word = '0;
  logic [31:0] rdata_o;
  logic [15:0] status_o;
  logic [15:0] st = 16'h0;
  logic [PW-1:0] pos = '0;
  logic link_clk, link_data, poll_req_o, irq_o, busy, m1, m2, e1, e2;
  logic first = 1'b1;
  logic rd_seen = 1'b0;
  logic [7:0] tbl [5] = '{8'h40, 8'h50, 8'h1f, 8'h1f, 8'h61};
  spc_note_t notes[$];
  spc_note_t nt;
  int n_mismatch = 0;
  int num_checks = 0;
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end

  spc_position_status #(.POS_W(PW)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_clk_i(link_clk),
    .link_data_i(link_data), .poll_req_o(poll_req_o), .status_o(status_o), .irq_o(irq_o));
  spc_enc_model #(.POS_W(PW)) u_enc (.go_i(go), .cut_i(cut), .word_i(word),
    .link_clk_o(link_clk), .link_data_o(link_data), .busy_o(busy));

  always #5 mclk_i = ~mclk_i;
  // Read data stand only in the cycle after the strobe
  always @(posedge mclk_i)
  begin
    if (rd_seen)
    begin
      nt = notes.pop_front();
      `CHK(nt.nm, nt.e & nt.m, rdata_o & nt.m)
    end
    rd_seen = rd_i;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e,
                    input logic [31:0] m);
    // Let halt and reject flags reach the status image
    repeat (3) @(posedge mclk_i);
    notes.push_back('{nm, e, m});
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
  endtask : rd

  task automatic look();
    rd(spc_pkg::OFS_STATUS, "status", {16'h0, st}, 32'hffff);
    rd(spc_pkg::OFS_POSITION, "position", {24'h0, pos}, '1);
  endtask : look

  task automatic frame(input logic [PW-1:0] p, input logic [3:0] s, input logic take);
    @(posedge mclk_i);
    word <= {p, s};
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    for (int i = 0; i < 400 && busy !== 1'b0; i++)
      @(posedge mclk_i);
    repeat (220) @(posedge mclk_i);
    if (take)
    begin
      e1 = p == 8'h40;
      e2 = p == 8'h50;
      m1 = m1 | e1;
      m2 = m2 | e2;
      st = {!first && p > pos, !first && p < pos, p >= 8'h50, m2, e2, p >= 8'h40, m1, e1,
            st[7], 3'h0, p < 8'h20, p > 8'h60, 1'b0, |(s & 4'h5)};
      pos = p;
      first = 1'b0;
    end
  endtask : frame

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (30000) @(posedge mclk_i);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    m1 = 1'b0;
    m2 = 1'b0;
    void'($urandom(32'h373d));
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (220) @(posedge mclk_i);
    rd(8'h30, "unmapped", 32'h0, '1);
    wr(spc_pkg::OFS_LOW_LIMIT, 32'h20);
    wr(spc_pkg::OFS_HIGH_LIMIT, 32'h60);
    wr(spc_pkg::OFS_REF1, 32'h40);
    wr(spc_pkg::OFS_REF2, 32'h50);
    wr(spc_pkg::OFS_DIAG_EN, 32'h5);
    wr(spc_pkg::OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      frame(i < 3 ? 8'($urandom) : tbl[i-3], 4'($urandom), 1'b1);
      look();
    end
    $display("test frames done");
    `CHK("irq", 1'b1, irq_o)
    wr(spc_pkg::OFS_IRQ_STAT, 32'h1);
    repeat (3) @(posedge mclk_i);
    `CHK("irq", 1'b0, irq_o)
    $display("test irq done");
    wr(spc_pkg::OFS_CTRL, 32'h2);
    m1 = 1'b0;
    st[9] = 1'b0;
    look();
    frame(8'h50, 4'h0, 1'b1);
    wr(spc_pkg::OFS_STATUS, 32'h0);
    look();
    frame(8'h51, 4'h0, 1'b1);
    wr(spc_pkg::OFS_CTRL, 32'h4);
    m2 = 1'b0;
    st[12] = 1'b0;
    look();
    frame(8'h50, 4'h0, 1'b1);
    frame(8'h51, 4'h0, 1'b1);
    wr(spc_pkg::OFS_STATUS, 32'h0);
    m2 = 1'b0;
    st[12] = 1'b0;
    look();
    $display("test markers done");
    wr(spc_pkg::OFS_CTRL, 32'h1);
    st[7] = 1'b1;
    look();
    `CHK("poll", 1'b0, poll_req_o)
    frame(8'h10, 4'h0, 1'b0);
    look();
    wr(spc_pkg::OFS_CTRL, 32'h0);
    st[7] = 1'b0;
    look();
    `CHK("poll", 1'b1, poll_req_o)
    wr(spc_pkg::OFS_LOW_LIMIT, 32'h70);
    rd(spc_pkg::OFS_STATUS, "reject", 32'h90, 32'h90);
    wr(spc_pkg::OFS_LOW_LIMIT, 32'h20);
    rd(spc_pkg::OFS_STATUS, "reject", 32'h0, 32'h90);
    $display("test halt done");
    cut <= 1'b1;
    frame(8'h0, 4'h0, 1'b0);
    rd(spc_pkg::OFS_STATUS, "fault", 32'h2, 32'h2);
    rd(spc_pkg::OFS_IRQ_STAT, "fault event", 32'h8, 32'h8);
    cut <= 1'b0;
    frame(8'h22, 4'h0, 1'b0);
    rd(spc_pkg::OFS_STATUS, "fault", 32'h0, 32'h2);
    $display("test fault done");
    repeat (3) @(posedge mclk_i);
    print_verdict();
  end
endmodule : ssi_position_status_compare_tb
